// [pkg/abh_consts.vh]
// Constants for the converter byte output and handshake block.
// Assumes inclusion by bare name from design files.
`ifndef ABH_CONSTS_VH
`define ABH_CONSTS_VH
`define ABH_HOLD_RESTART_CYC 3'h7
`define ABH_BYTES_16 2'h3
`define ABH_BYTES_14 2'h2
`define ABH_ST_IDLE 2'h0
`define ABH_ST_WAIT 2'h1
`define ABH_ST_LOAD 2'h2
`define ABH_ST_HOLD 2'h3
`define ABH_BYTE_HIGH 2'h0
`define ABH_BYTE_MID 2'h1
`define ABH_BYTE_LOW 2'h2
`endif

// [design/abh_hold_ctl.v]
// Run/hold gate: stops the converter at the end of auto-zero while hold is low.
// Assumes run_hold_in synchronous to clock_in.
`include "abh_consts.vh"
module abh_hold_ctl (
  input wire clock_in, // Converter clock
  input wire rstn_in, // Synchronous reset, active low
  input wire autozero_end_in, // Auto-zero finished this cycle
  input wire run_hold_in, // High to run
  output wire integrate_start_out // Pulse: start integrate
);
  reg waiting_r;
  reg [2:0] count_r;
  reg counting_r;
  reg start_r;
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      waiting_r <= 1'b0;
      counting_r <= 1'b0;
      count_r <= 3'h0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (autozero_end_in && !waiting_r && !counting_r) begin
        if (run_hold_in)
          start_r <= 1'b1;
        else
          waiting_r <= 1'b1;
      end
      if (waiting_r && run_hold_in) begin
        waiting_r <= 1'b0;
        counting_r <= 1'b1;
        count_r <= 3'h1;
      end
      if (counting_r) begin
        if (count_r == `ABH_HOLD_RESTART_CYC) begin
          counting_r <= 1'b0;
          start_r <= 1'b1;
        end else begin
          count_r <= count_r + 3'h1;
        end
      end
    end
  end
  assign integrate_start_out = start_r;
endmodule

// [design/abh_output_port.v]
// Byte output port of a dual-slope converter: direct and handshake modes.
// Assumes all inputs synchronous to clock_in except direct-mode enables.
`include "abh_consts.vh"
module abh_output_port #(
  parameter BYTES = 3 // 3 for 16-bit, 2 for 14/12-bit
) (
  input wire clock_in, // Internal converter clock
  input wire rstn_in, // Synchronous reset, active low
  input wire mode_in, // Output mode select
  input wire run_hold_in, // Run/hold
  input wire autozero_end_in, // Pulse: auto-zero finished
  input wire latch_req_in, // Pulse: conversion done, latch result
  input wire [7:0] result_low_in, // Converter bits 1-8
  input wire [7:0] result_mid_in, // Converter middle byte
  input wire [7:0] result_high_in, // Sign, overrange, upper bits
  input wire send_ready_in, // Receiver able to accept
  input wire chip_enable_load_strobe_in, // Direct chip enable, low active
  input wire low_byte_enable_in, // Direct low byte enable
  input wire middle_byte_enable_in, // Direct middle byte enable
  input wire high_byte_enable_in, // Direct high byte enable
  output reg chip_enable_load_strobe_out, // Driven chip enable/load, low active
  output reg low_byte_enable_out, // Driven low byte enable
  output reg middle_byte_enable_out, // Driven middle byte enable
  output reg high_byte_enable_out, // Driven high byte enable
  output wire enables_oe_out, // Enable pins driven
  output wire [7:0] low_data_out, // Low byte data
  output wire [7:0] mid_data_out, // Middle byte data
  output wire [7:0] high_data_out, // High byte data
  output wire low_data_oe_out, // Low byte drive
  output wire mid_data_oe_out, // Middle byte drive
  output wire high_data_oe_out, // High byte drive
  output wire status_out, // Conversion in progress
  output wire handshake_out, // Internal handshake flag
  output wire integrate_start_out // Pulse: integrate begins
);
  reg [7:0] low_r;
  reg [7:0] mid_r;
  reg [7:0] high_r;
  reg hs_r;
  reg mode_d_r;
  reg pend_r;
  reg status_r;
  reg stat_fall_r;
  reg [1:0] st_r;
  reg [1:0] byte_r;
  reg sense_r;
  reg [2:0] data_on_r;
  wire start_int;
  wire last_byte;
  wire mode_rise;
  integer i;

  // --------------------------------------------------------------
  // Hold control
  // --------------------------------------------------------------
  abh_hold_ctl u_hold (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .autozero_end_in(autozero_end_in),
    .run_hold_in(run_hold_in),
    .integrate_start_out(start_int)
  );
  assign integrate_start_out = start_int;

  // --------------------------------------------------------------
  // Result latch and status
  // --------------------------------------------------------------
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      low_r <= 8'h00;
      mid_r <= 8'h00;
      high_r <= 8'h00;
      status_r <= 1'b0;
    end else begin
      if (start_int)
        status_r <= 1'b1;
      if (latch_req_in && status_r)
        status_r <= 1'b0;
      if (latch_req_in && !hs_r && status_r) begin
        low_r <= result_low_in;
        mid_r <= result_mid_in;
        high_r <= result_high_in;
      end
    end
  end

  // Half-clock copy keeps status up until the falling edge after the latch edge
  always @(negedge clock_in) begin
    if (!rstn_in)
      stat_fall_r <= 1'b0;
    else
      stat_fall_r <= status_r;
  end
  assign status_out = status_r || stat_fall_r;

  // --------------------------------------------------------------
  // Handshake entry and exit
  // --------------------------------------------------------------
  assign last_byte = (byte_r == `ABH_BYTE_LOW);
  assign mode_rise = mode_in && !mode_d_r;

  always @(posedge clock_in) begin
    if (!rstn_in) begin
      hs_r <= 1'b0;
      mode_d_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      mode_d_r <= mode_in;
      if (!hs_r) begin
        if (latch_req_in && status_r && mode_in)
          hs_r <= 1'b1;
        else if (latch_req_in && mode_rise)
          pend_r <= 1'b1;
        else if (mode_rise || pend_r) begin
          hs_r <= 1'b1;
          pend_r <= 1'b0;
        end
      end else if (st_r == `ABH_ST_HOLD && sense_r && last_byte) begin
        hs_r <= 1'b0;
      end
    end
  end
  assign handshake_out = hs_r;

  // --------------------------------------------------------------
  // Falling-edge sense of send-ready
  // --------------------------------------------------------------
  always @(negedge clock_in) begin
    if (!rstn_in)
      sense_r <= 1'b0;
    else
      sense_r <= send_ready_in;
  end

  // --------------------------------------------------------------
  // Byte sequencer
  // --------------------------------------------------------------
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      st_r <= `ABH_ST_IDLE;
      byte_r <= `ABH_BYTE_HIGH;
      chip_enable_load_strobe_out <= 1'b1;
      high_byte_enable_out <= 1'b1;
      middle_byte_enable_out <= 1'b1;
      low_byte_enable_out <= 1'b1;
    end else begin
      chip_enable_load_strobe_out <= 1'b1;
      case (st_r)
        `ABH_ST_IDLE: begin
          if (hs_r) begin
            st_r <= `ABH_ST_WAIT;
            byte_r <= `ABH_BYTE_HIGH;
          end
        end
        `ABH_ST_WAIT: begin
          if (sense_r) begin
            st_r <= `ABH_ST_LOAD;
            chip_enable_load_strobe_out <= 1'b0;
            high_byte_enable_out <= (byte_r != `ABH_BYTE_HIGH);
            middle_byte_enable_out <= (byte_r != `ABH_BYTE_MID);
            low_byte_enable_out <= (byte_r != `ABH_BYTE_LOW);
          end
        end
        `ABH_ST_LOAD: begin
          st_r <= `ABH_ST_HOLD;
        end
        `ABH_ST_HOLD: begin
          if (sense_r) begin
            high_byte_enable_out <= 1'b1;
            middle_byte_enable_out <= 1'b1;
            low_byte_enable_out <= 1'b1;
            if (last_byte) begin
              st_r <= `ABH_ST_IDLE;
            end else begin
              st_r <= `ABH_ST_LOAD;
              chip_enable_load_strobe_out <= 1'b0;
              if (byte_r == `ABH_BYTE_HIGH && BYTES == 3) begin
                byte_r <= `ABH_BYTE_MID;
                middle_byte_enable_out <= 1'b0;
              end else begin
                byte_r <= `ABH_BYTE_LOW;
                low_byte_enable_out <= 1'b0;
              end
            end
          end
        end
        default: st_r <= `ABH_ST_IDLE;
      endcase
    end
  end

  // Data of the current byte stays on until the falling edge sensing send-ready
  always @(negedge clock_in) begin
    if (!rstn_in) begin
      data_on_r <= 3'h0;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if ((st_r == `ABH_ST_LOAD || st_r == `ABH_ST_HOLD) && byte_r == i[1:0])
          data_on_r[i] <= !(st_r == `ABH_ST_HOLD && send_ready_in);
        else
          data_on_r[i] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------
  wire drive_hs = hs_r || mode_in || st_r != `ABH_ST_IDLE;
  assign enables_oe_out = drive_hs;
  wire ce_dir = !drive_hs && !chip_enable_load_strobe_in;
  // Data turns on with the load strobe, a half clock ahead of the falling-edge flag
  wire load_high = st_r == `ABH_ST_LOAD && byte_r == `ABH_BYTE_HIGH;
  wire load_mid = st_r == `ABH_ST_LOAD && byte_r == `ABH_BYTE_MID;
  wire load_low = st_r == `ABH_ST_LOAD && byte_r == `ABH_BYTE_LOW;
  assign high_data_oe_out = drive_hs ? (data_on_r[0] || load_high) :
    (ce_dir && !high_byte_enable_in);
  assign mid_data_oe_out = drive_hs ? (data_on_r[1] || load_mid) :
    (ce_dir && !middle_byte_enable_in && BYTES == 3);
  assign low_data_oe_out = drive_hs ? (data_on_r[2] || load_low) :
    (ce_dir && !low_byte_enable_in);
  assign high_data_out = high_r;
  assign mid_data_out = mid_r;
  assign low_data_out = low_r;
endmodule

// [tb/abh_output_port_asserts.sv]
// Checker for the byte output port, bound onto its top module.
// Assumes one clock domain and a synchronous active-low reset.
module abh_output_port_asserts #(
  parameter BYTES = 3
) (
  input wire clock_in, // Converter clock
  input wire rstn_in, // Reset, active low
  input wire mode_in, // Mode select
  input wire send_ready_in, // Receiver ready
  input wire chip_enable_load_strobe_in, // Direct chip enable
  input wire low_byte_enable_in, // Direct low enable
  input wire high_byte_enable_in, // Direct high enable
  input wire chip_enable_load_strobe_out, // Load strobe
  input wire low_byte_enable_out, // Low enable
  input wire middle_byte_enable_out, // Middle enable
  input wire high_byte_enable_out, // High enable
  input wire enables_oe_out, // Enable pins driven
  input wire [7:0] low_data_out, // Low byte
  input wire low_data_oe_out, // Low drive
  input wire high_data_oe_out, // High drive
  input wire status_out, // Status
  input wire handshake_out // Handshake flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  strobe_one_clk_a: assert property ($fell(chip_enable_load_strobe_out) |=>
    $rose(chip_enable_load_strobe_out)) else $error("load strobe not one clock");
  strobe_with_en_a: assert property ($fell(chip_enable_load_strobe_out) |->
    $fell(high_byte_enable_out) || $fell(middle_byte_enable_out) || $fell(low_byte_enable_out))
    else $error("load strobe without byte enable");
  strobe_in_hs_a: assert property ($fell(chip_enable_load_strobe_out) |-> handshake_out)
    else $error("load strobe outside handshake");
  mid_only_16_a: assert property ($fell(middle_byte_enable_out) |-> BYTES == 3)
    else $error("middle byte on short variant");
  direct_low_a: assert property (!enables_oe_out |-> low_data_oe_out ==
    (!chip_enable_load_strobe_in && !low_byte_enable_in)) else $error("low drive wrong");
  direct_high_a: assert property (!enables_oe_out |-> high_data_oe_out ==
    (!chip_enable_load_strobe_in && !high_byte_enable_in)) else $error("high drive wrong");
  status_hold_a: assert property (!status_out && $past(!status_out) |->
    $stable(low_data_out)) else $error("result changed while status low");
  hs_no_latch_a: assert property (handshake_out && $past(handshake_out) |->
    $stable(low_data_out)) else $error("result latched in handshake");
  pins_driven_a: assert property (handshake_out || mode_in |-> ##[0:1] enables_oe_out)
    else $error("enable pins not driven");
  stall_hold_a: assert property (enables_oe_out && !high_byte_enable_out && !send_ready_in
    |-> high_data_oe_out ##1 !high_byte_enable_out) else $error("stall released byte");
  cover property ($fell(middle_byte_enable_out));
  cover property ($fell(handshake_out));
  cover property (!send_ready_in && !high_byte_enable_out && enables_oe_out);
endmodule
bind abh_output_port abh_output_port_asserts #(.BYTES(BYTES)) chk (.*);

// [tb/abh_uart_model.sv]
// Transmitter buffer model on the handshake side of the port.
// Assumes the bench resolves the three byte buses into one.
module abh_uart_model (
  input wire clock_in, // Converter clock
  input wire slow_in, // Stall after each byte
  input wire load_n_in, // Load strobe, low active
  input wire [7:0] bus_in, // Resolved data lines
  output reg send_ready_out, // Buffer empty
  output reg [23:0] got_out // Last bytes captured
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] wait_r;
  initial begin
    send_ready_out = 1'b1;
    got_out = 24'h000000;
    wait_r = 3'h0;
  end
  always @(posedge load_n_in) begin
    got_out <= {got_out[15:0], bus_in};
  end
  // Slow mode keeps the buffer full for eight clocks after a load
  always @(posedge clock_in) begin
    if (!load_n_in && slow_in) begin
      send_ready_out <= 1'b0;
      wait_r <= 3'h7;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end else begin
      send_ready_out <= 1'b1;
    end
  end
endmodule

// [tb/abh_output_port_tb.sv]
// Bench for the byte output port: direct reads and handshake sequences.
// Assumes the transmitter model and the bound checker.
module abh_output_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clock_in, rstn_in, mode_in, run_hold_in, az, latch, slow, ce_d, l_d, m_d, h_d;
  reg [23:0] res;
  reg [7:0] cyc;
  reg [6:0] rows [0:4];
  integer err_total, n_tests, i, n;
  wire ce_o, l_o, m_o, h_o, eoe, loe, moe, hoe, st, hs, ist, rdy;
  wire [7:0] ld, md, hd;
  wire [23:0] got;
  // Enable pins: bench-driven ce_d/l_d/m_d/h_d when the port does not drive; data bus changes when released
  wire ce_p = eoe ? ce_o : ce_d;
  wire l_p = eoe ? l_o : l_d;
  wire m_p = eoe ? m_o : m_d;
  wire h_p = eoe ? h_o : h_d;
  wire [7:0] bus = hoe ? hd : moe ? md : loe ? ld : cyc;
  abh_output_port #(.BYTES(3)) dut (.clock_in(clock_in), .rstn_in(rstn_in), .mode_in(mode_in),
    .run_hold_in(run_hold_in), .autozero_end_in(az), .latch_req_in(latch),
    .result_low_in(res[7:0]), .result_mid_in(res[15:8]), .result_high_in(res[23:16]),
    .send_ready_in(rdy), .chip_enable_load_strobe_in(ce_p), .low_byte_enable_in(l_p),
    .middle_byte_enable_in(m_p), .high_byte_enable_in(h_p),
    .chip_enable_load_strobe_out(ce_o), .low_byte_enable_out(l_o),
    .middle_byte_enable_out(m_o), .high_byte_enable_out(h_o), .enables_oe_out(eoe),
    .low_data_out(ld), .mid_data_out(md), .high_data_out(hd), .low_data_oe_out(loe),
    .mid_data_oe_out(moe), .high_data_oe_out(hoe), .status_out(st), .handshake_out(hs),
    .integrate_start_out(ist));
  abh_uart_model far (.clock_in(clock_in), .slow_in(slow), .load_n_in(ce_o), .bus_in(bus),
    .send_ready_out(rdy), .got_out(got));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("tests=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task wait_start;
    begin
      n = 0;
      #1;
      while (ist !== 1'b1 && n < 40) begin
        @(posedge clock_in) #1;
        n = n + 1;
      end
    end
  endtask
  task conv(input [23:0] v);
    begin
      @(posedge clock_in) az <= 1'b1;
      @(posedge clock_in) az <= 1'b0;
      wait_start;
      @(posedge clock_in) res <= v;
      latch <= 1'b1;
      @(posedge clock_in) latch <= 1'b0;
    end
  endtask
  task hs_done;
    begin
      for (i = 0; i < 20 && hs !== 1'b1; i = i + 1) @(posedge clock_in) #1;
      for (i = 0; i < 400 && hs !== 1'b0; i = i + 1) @(posedge clock_in) #1;
    end
  endtask
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge clock_in) cyc <= cyc + 8'h01;
  initial begin
    repeat (5000) @(posedge clock_in);
    err_total = err_total + 1;
    final_report;
  end
  initial begin
    {rstn_in, mode_in, az, latch, slow, res, cyc} = 0;
    {run_hold_in, ce_d, l_d, m_d, h_d} = 5'h1F;
    {err_total, n_tests} = 0;
    rows[0] = 7'h1C;
    rows[1] = 7'h2A;
    rows[2] = 7'h31;
    rows[3] = 7'h40;
    rows[4] = 7'h78;
    repeat (10) @(posedge clock_in);
    rstn_in <= 1'b1;
    #1 chk({hs, eoe, st}, 3'h0);
    conv(24'hC35AA5);
    repeat (3) @(posedge clock_in) #1;
    chk(st, 1'b0);
    chk({hd, md, ld}, 24'hC35AA5);
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clock_in) {ce_d, l_d, m_d, h_d} <= rows[i][6:3];
      @(posedge clock_in) #1 chk({loe, moe, hoe}, rows[i][2:0]);
    end
    @(posedge clock_in) run_hold_in <= 1'b0;
    az <= 1'b1;
    @(posedge clock_in) az <= 1'b0;
    wait_start;
    chk(n, 40);
    @(posedge clock_in) run_hold_in <= 1'b1;
    wait_start;
    chk(n, 8);
    @(posedge clock_in) mode_in <= 1'b1;
    hs_done;
    chk(got, 24'hC35AA5);
    conv(24'h814218);
    hs_done;
    chk(got, 24'h814218);
    chk({eoe, ce_o, l_o, m_o, h_o}, 5'h1F);
    slow <= 1'b1;
    conv(24'h3C6699);
    for (i = 0; i < 20 && hs !== 1'b1; i = i + 1) @(posedge clock_in) #1;
    conv(24'h112233);
    hs_done;
    chk(got, 24'h3C6699);
    chk(ld, 8'h99);
    @(posedge clock_in) mode_in <= 1'b0;
    repeat (2) @(posedge clock_in) #1;
    chk(eoe, 1'b0);
    @(posedge clock_in) mode_in <= 1'b1;
    @(posedge clock_in) mode_in <= 1'b0;
    hs_done;
    chk(got, 24'h3C6699);
    final_report;
  end
endmodule
